//--- core/rocc_pkg.sv
// package with register map, field layout, reset values and timing for the clock output control
package rocc_pkg;
	localparam logic [7:0] CLK_PAD_CFG_ADDR = 8'h03;
	localparam logic [7:0] OSC_CTRL_ADDR = 8'h12;
	localparam int FREQ_SEL_LSB = 0;
	localparam int SHADOW_BIT = 3;
	localparam int CLK_DRIVE_LSB = 4;
	localparam int PAD_DRIVE_LSB = 6;
	localparam int TRIM_LSB = 0;
	localparam int MODE_LSB = 4;
	localparam logic [2:0] FREQ_SEL_RST = 3'h1;
	localparam logic SHADOW_RST = 1'b1;
	localparam logic [1:0] CLK_DRIVE_RST = 2'h1;
	localparam logic [1:0] PAD_DRIVE_RST = 2'h0;
	localparam logic [3:0] MODE_RST = 4'hF;
	localparam logic [3:0] TRIM_RST = 4'h0;
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_EXT = 4'h4;
	localparam logic [3:0] MODE_INT = 4'hF;
	localparam logic [2:0] FREQ_NONE = 3'h0;
	localparam logic [2:0] FREQ_1M = 3'h1;
	localparam logic [2:0] FREQ_16M = 3'h5;
	// raw reference is 16 MHz, divider counter spans 16 raw cycles
	localparam int DIV_W = 4;
	localparam int CLK_MHZ = 25;
	localparam int SETTLE_US = 500;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int SETTLE_W = 14;
	typedef struct packed {
		logic [1:0] pad_drive;
		logic [1:0] clk_drive;
		logic shadow;
		logic [2:0] freq_sel;
	} rocc_clk_cfg_t;
	typedef struct packed {
		logic [3:0] mode;
		logic [3:0] trim;
	} rocc_osc_cfg_t;
endpackage

//--- core/rocc_div.sv
// prescaler that divides the raw reference into the output clock, switching only at cycle ends
`timescale 1ns/1ps
`default_nettype none
module rocc_div
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic raw_tick_i,
	input wire logic [2:0] sel_i,
	output logic [2:0] sel_used_o,
	output logic clk_o
);
	logic [rocc_pkg::DIV_W-1:0] cnt_r;
	logic [rocc_pkg::DIV_W-1:0] cnt_nxt;
	logic [2:0] sel_r;
	logic clk_r;
	logic [rocc_pkg::DIV_W-1:0] half_mask;
	logic period_end;
	logic sel_valid;

	// half period length minus one, in raw ticks; 16 MHz toggles on every tick
	function automatic logic [rocc_pkg::DIV_W-1:0] half_of(input logic [2:0] s);
		case (s)
			3'h1: half_of = 4'hF;
			3'h2: half_of = 4'h7;
			3'h3: half_of = 4'h3;
			3'h4: half_of = 4'h1;
			default: half_of = 4'h0;
		endcase
	endfunction

	assign sel_valid = (sel_r >= rocc_pkg::FREQ_1M) && (sel_r <= rocc_pkg::FREQ_16M); // [R2]
	assign half_mask = half_of(sel_r);
	// a full output period ends when the high half finishes and the pin is about to fall
	assign period_end = raw_tick_i && (cnt_r == half_mask) && (clk_r == 1'b1 || !sel_valid);
	assign cnt_nxt = (cnt_r == half_mask) ? '0 : cnt_r + 4'h1;
	assign sel_used_o = sel_r;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_r <= '0;
			sel_r <= rocc_pkg::FREQ_SEL_RST;
			clk_r <= 1'b0;
		end
		else if (ce_i && raw_tick_i)
		begin
			// selection taken only at a period boundary so no pulse is cut short
			if (period_end)
			begin
				sel_r <= sel_i; // [R13]
				cnt_r <= '0;
				clk_r <= 1'b0;
			end
			else
			begin
				cnt_r <= cnt_nxt; // [R1]
				if (cnt_r == half_mask)
					clk_r <= sel_valid ? ~clk_r : 1'b0;
			end
		end
	end

	assign clk_o = clk_r;

	property p_no_clock_codes;
		@(posedge clk_i) disable iff (rst_i)
		!sel_valid |-> !clk_r;
	endproperty
	a_no_clock_codes: assert property (p_no_clock_codes) else $error("clock on idle code"); // [R2]

	property p_switch_boundary;
		@(posedge clk_i) disable iff (rst_i)
		(sel_r != $past(sel_r)) |-> ($past(period_end) && !clk_r);
	endproperty
	a_switch_boundary: assert property (p_switch_boundary) else $error("switch mid period"); // [R13]
endmodule
`default_nettype wire

//--- core/rocc_top.sv
// reference oscillator configuration, clock output prescaler and shadowed frequency select
//
// Overview of operation
// [R1] output clock divided from 16 MHz raw reference
// [R2] select codes 1..5 give 1..16 MHz, others none
// [R3] shadow off: new select applies at once
// [R4] shadow on: new select waits for sleep exit
// [R5] shadow resets to 1, select resets to 1
// [R6] clock pin drive code at 5:4, reset 1
// [R7] other pad drive code at 7:6, reset 0
// [R8] oscillator mode 0 off, 4 external, 15 internal
// [R9] trim code 3:0 steps 0.3 pF, reset 0
// [R10] host selects external mode for external reference
// [R11] host disables unused output with no-clock code
// [R12] allow 500 us oscillator settling before use
// [R13] frequency switches only at output cycle boundary
// [R14] pending select held readable, committed on wake
`timescale 1ns/1ps
`default_nettype none
module rocc_top
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic raw_tick_i,
	input wire logic sleep_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic divided_clock_out_pin_o,
	output logic [1:0] clock_pin_drive_strength_o,
	output logic [1:0] pad_drive_strength_o,
	output logic [3:0] osc_mode_o,
	output logic [3:0] osc_cap_trim_o,
	output logic osc_enable_o,
	output logic osc_ext_input_o,
	output logic osc_stable_o,
	output logic [2:0] out_freq_active_o
);
	rocc_pkg::rocc_clk_cfg_t clk_cfg_r;
	rocc_pkg::rocc_osc_cfg_t osc_cfg_r;
	logic [2:0] active_sel_r;
	logic [7:0] rdata_r;
	logic [rocc_pkg::SETTLE_W-1:0] settle_cnt_r;
	logic sleep_q1_r;
	logic sleep_q2_r;
	logic sleep_q3_r;
	logic sleep_s_r;
	logic wake_evt;
	logic wr_clk_cfg;
	logic wr_osc_cfg;
	logic hit_clk_cfg;
	logic hit_osc_cfg;
	logic mode_legal;
	logic osc_on;
	logic [7:0] rd_mux;
	logic [2:0] sel_used;
	logic [2:0] wr_freq_sel;
	logic wr_shadow;
	logic [3:0] wr_mode;
	logic [3:0] wr_trim;

	function automatic logic mode_ok(input logic [3:0] m);
		mode_ok = (m == rocc_pkg::MODE_OFF) || (m == rocc_pkg::MODE_EXT)
			|| (m == rocc_pkg::MODE_INT);
	endfunction

	assign hit_clk_cfg = (addr_i == rocc_pkg::CLK_PAD_CFG_ADDR);
	assign hit_osc_cfg = (addr_i == rocc_pkg::OSC_CTRL_ADDR);
	assign wr_clk_cfg = wr_i && hit_clk_cfg;
	assign wr_osc_cfg = wr_i && hit_osc_cfg;
	// write data split into the fields that each register takes
	assign wr_freq_sel = wdata_i[rocc_pkg::FREQ_SEL_LSB +: 3];
	assign wr_shadow = wdata_i[rocc_pkg::SHADOW_BIT];
	assign wr_mode = wdata_i[rocc_pkg::MODE_LSB +: 4];
	assign wr_trim = wdata_i[rocc_pkg::TRIM_LSB +: 4];
	assign mode_legal = mode_ok(wr_mode);
	assign osc_on = osc_cfg_r.mode != rocc_pkg::MODE_OFF;
	// sleep is a pin level from another domain: changes count when stages two and three agree
	assign wake_evt = sleep_s_r && (sleep_q2_r == sleep_q3_r) && !sleep_q3_r;
	assign rd_mux = hit_clk_cfg ? 8'(clk_cfg_r) : (hit_osc_cfg ? 8'(osc_cfg_r) : 8'h00);

	// sleep synchroniser and filtered level
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sleep_q1_r <= 1'b0;
			sleep_q2_r <= 1'b0;
			sleep_q3_r <= 1'b0;
			sleep_s_r <= 1'b0;
		end
		else if (ce_i)
		begin
			sleep_q1_r <= sleep_i;
			sleep_q2_r <= sleep_q1_r;
			sleep_q3_r <= sleep_q2_r;
			if (sleep_q2_r == sleep_q3_r)
				sleep_s_r <= sleep_q3_r;
		end
	end

	// clock pin and pad configuration register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			clk_cfg_r.pad_drive <= rocc_pkg::PAD_DRIVE_RST; // [R7]
			clk_cfg_r.clk_drive <= rocc_pkg::CLK_DRIVE_RST; // [R6]
			clk_cfg_r.shadow <= rocc_pkg::SHADOW_RST; // [R5]
			clk_cfg_r.freq_sel <= rocc_pkg::FREQ_SEL_RST; // [R5]
		end
		else if (ce_i && wr_clk_cfg)
			clk_cfg_r <= wdata_i; // [R14]
	end

	// active select: follows writes at once unless shadowed, then waits for wake
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			active_sel_r <= rocc_pkg::FREQ_SEL_RST;
		else if (ce_i)
		begin
			if (wr_clk_cfg && !wr_shadow)
				active_sel_r <= wr_freq_sel; // [R3]
			else if (wake_evt)
				active_sel_r <= clk_cfg_r.freq_sel; // [R4] [R14]
		end
	end

	// oscillator control register; reserved mode codes are not accepted
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			osc_cfg_r.mode <= rocc_pkg::MODE_RST; // [R8]
			osc_cfg_r.trim <= rocc_pkg::TRIM_RST; // [R9]
		end
		else if (ce_i && wr_osc_cfg)
		begin
			if (mode_legal)
				osc_cfg_r.mode <= wr_mode; // [R8]
			osc_cfg_r.trim <= wr_trim; // [R9]
		end
	end

	// settle timer restarts whenever the oscillator is off
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			settle_cnt_r <= '0;
		else if (ce_i)
		begin
			if (!osc_on)
				settle_cnt_r <= '0;
			else if (settle_cnt_r != rocc_pkg::SETTLE_W'(rocc_pkg::SETTLE_CYC))
				settle_cnt_r <= settle_cnt_r + 14'h0001; // [R12]
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_r <= 8'h00;
		else if (ce_i && rd_i)
			rdata_r <= rd_mux;
	end

	// output clock frozen at its level until the reference has settled, low from reset
	rocc_div u_div
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i && osc_stable_o),
		.raw_tick_i(raw_tick_i),
		.sel_i(active_sel_r),
		.sel_used_o(sel_used),
		.clk_o(divided_clock_out_pin_o)
	);

	assign rdata_o = rdata_r;
	assign clock_pin_drive_strength_o = clk_cfg_r.clk_drive; // [R6]
	assign pad_drive_strength_o = clk_cfg_r.pad_drive; // [R7]
	assign osc_mode_o = osc_cfg_r.mode;
	assign osc_cap_trim_o = osc_cfg_r.trim;
	assign osc_enable_o = osc_on;
	assign osc_ext_input_o = osc_cfg_r.mode == rocc_pkg::MODE_EXT; // [R10]
	assign osc_stable_o = settle_cnt_r == rocc_pkg::SETTLE_W'(rocc_pkg::SETTLE_CYC); // [R12]
	assign out_freq_active_o = sel_used;

	property p_immediate;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr_clk_cfg && !wdata_i[3]) |=> (active_sel_r == $past(wdata_i[2:0]));
	endproperty
	a_immediate: assert property (p_immediate) else $error("unshadowed select not applied"); // [R3]

	property p_shadow_hold;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr_clk_cfg && wdata_i[3] && !wake_evt) |=> (active_sel_r == $past(active_sel_r));
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("shadow applied early"); // [R4]

	property p_wake_commit;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wake_evt && !wr_clk_cfg) |=> (active_sel_r == clk_cfg_r.freq_sel);
	endproperty
	a_wake_commit: assert property (p_wake_commit) else $error("pending not committed"); // [R14]

	property p_reset_vals;
		@(posedge clk_i)
		$fell(rst_i) |-> (clk_cfg_r == 8'h19 && osc_cfg_r == 8'hF0);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("wrong reset values"); // [R5]

	property p_drive_out;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr_clk_cfg) |=> (clock_pin_drive_strength_o == $past(wdata_i[5:4])
			&& pad_drive_strength_o == $past(wdata_i[7:6]));
	endproperty
	a_drive_out: assert property (p_drive_out) else $error("drive fields not written"); // [R6]

	property p_pad_drive;
		@(posedge clk_i) disable iff (rst_i)
		!(ce_i && wr_clk_cfg) |=> $stable(pad_drive_strength_o);
	endproperty
	a_pad_drive: assert property (p_pad_drive) else $error("pad drive changed without write"); // [R7]

	property p_mode_legal;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> mode_ok(osc_cfg_r.mode);
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("reserved oscillator mode held"); // [R8]

	property p_trim;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr_osc_cfg) |=> (osc_cap_trim_o == $past(wdata_i[3:0]));
	endproperty
	a_trim: assert property (p_trim) else $error("trim not written"); // [R9]

	property p_settle;
		@(posedge clk_i) disable iff (rst_i)
		!osc_on |=> !osc_stable_o;
	endproperty
	a_settle: assert property (p_settle) else $error("stable while oscillator off"); // [R12]

	property p_held_low;
		@(posedge clk_i) disable iff (rst_i)
		!osc_stable_o && !divided_clock_out_pin_o |=> !divided_clock_out_pin_o;
	endproperty
	a_held_low: assert property (p_held_low) else $error("clock started before settle"); // [R1]

	// pin config contents and read data follow the bus exactly, reserved oscillator modes excepted
	property p_shadow_store;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr_clk_cfg) |=> (clk_cfg_r == $past(wdata_i));
	endproperty
	a_shadow_store: assert property (p_shadow_store) else $error("config not stored"); // [R14]

	property p_read_back;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && rd_i && hit_clk_cfg) |=> (rdata_o == $past(clk_cfg_r));
	endproperty
	a_read_back: assert property (p_read_back) else $error("pin config read wrong"); // [R14]

	property p_osc_read;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && rd_i && hit_osc_cfg) |=> (rdata_o == $past(osc_cfg_r));
	endproperty
	a_osc_read: assert property (p_osc_read) else $error("osc config read wrong"); // [R9]

	property p_reserved_mode;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr_osc_cfg && !mode_legal) |=> $stable(osc_mode_o);
	endproperty
	a_reserved_mode: assert property (p_reserved_mode) else $error("reserved mode taken"); // [R8]

	// fields only move on a write, the select also on a wake
	property p_active_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(ce_i && (wr_clk_cfg || wake_evt)) |=> $stable(active_sel_r);
	endproperty
	a_active_hold: assert property (p_active_hold) else $error("select moved unasked"); // [R4]

	property p_clk_drive_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(ce_i && wr_clk_cfg) |=> $stable(clock_pin_drive_strength_o);
	endproperty
	a_clk_drive_hold: assert property (p_clk_drive_hold) else $error("drive changed"); // [R6]

	property p_trim_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(ce_i && wr_osc_cfg) |=> $stable(osc_cap_trim_o);
	endproperty
	a_trim_hold: assert property (p_trim_hold) else $error("trim changed unasked"); // [R9]

	property p_div_frozen;
		@(posedge clk_i) disable iff (rst_i)
		!osc_stable_o |=> ($stable(out_freq_active_o) && $stable(divided_clock_out_pin_o));
	endproperty
	a_div_frozen: assert property (p_div_frozen) else $error("divider ran unsettled"); // [R12]
endmodule
`default_nettype wire

//--- tb/rocc_host_model.sv
// host model running from the divided output clock
`timescale 1ns/1ps
`default_nettype none
module rocc_host_model
(
	input wire logic clk_i,
	input wire logic stable_i,
	output logic [15:0] edges_o
);
	logic [15:0] edge_cnt = 16'h0000;
	// the host counts its clock only once the reference has settled
	always @(posedge clk_i)
		if (stable_i)
			edge_cnt <= edge_cnt + 16'h0001;
	assign edges_o = edge_cnt;
endmodule
`default_nettype wire

//--- tb/rocc_top_test.sv
// self-checking bench for the clock output control
`timescale 1ns/1ps
`default_nettype none
module rocc_top_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic raw_tick_i = 1'b1;
	logic sleep_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata;
	logic pin, stable, en, ext;
	logic [1:0] cdrv, pdrv;
	logic [3:0] mode, trim;
	logic [2:0] act;
	logic [15:0] edges;
	int n_mismatch = 0;
	int checked = 0;
	rocc_top u_rocc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .raw_tick_i(raw_tick_i),
		.sleep_i(sleep_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.rdata_o(rdata), .divided_clock_out_pin_o(pin), .clock_pin_drive_strength_o(cdrv),
		.pad_drive_strength_o(pdrv), .osc_mode_o(mode), .osc_cap_trim_o(trim),
		.osc_enable_o(en), .osc_ext_input_o(ext), .osc_stable_o(stable),
		.out_freq_active_o(act));
	rocc_host_model u_rocc_host_model (.clk_i(pin), .stable_i(stable), .edges_o(edges));
	initial
	begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_i = a;
		wdata_i = d;
		wr_i = 1'b1;
		@(negedge clk_i);
		wr_i = 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_i);
		addr_i = a;
		rd_i = 1'b1;
		@(negedge clk_i);
		rd_i = 1'b0;
		@(negedge clk_i);
		chk({8'h00, rdata}, {8'h00, exp});
	endtask
	// measures how many cycles the output stays high after a switch has landed
	task automatic half(input logic [7:0] exp);
		int n;
		n = 0;
		repeat (80) @(negedge clk_i);
		// start from a rising edge so a high half already under way is not measured
		while (pin === 1'b1 && n < 100)
		begin
			@(negedge clk_i);
			n++;
		end
		n = 0;
		while (pin !== 1'b1 && n < 100)
		begin
			@(negedge clk_i);
			n++;
		end
		n = 0;
		while (pin === 1'b1 && n < 100)
		begin
			@(negedge clk_i);
			n++;
		end
		chk(16'(n), {8'h00, exp});
	endtask
	task automatic t_reset();
		rdchk(8'h03, 8'h19);
		rdchk(8'h12, 8'hF0);
		rdchk(8'h40, 8'h00);
		chk({13'h0, act}, 16'h0001);
		chk({15'h0, stable}, 16'h0000);
	endtask
	task automatic t_settle();
		int n;
		n = 0;
		while (stable !== 1'b1 && n < 13000)
		begin
			@(negedge clk_i);
			n++;
		end
		chk(16'(n > 12400 && n < 12600), 16'h0001);
	endtask
	task automatic t_immediate();
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h03, {5'h02, 3'(c)});
			half((c >= 1 && c <= 5) ? (8'h20 >> c) : 8'h00);
			chk({13'h0, act}, 16'(c));
		end
		chk(16'(edges > 16'h0000), 16'h0001);
	endtask
	task automatic t_shadow();
		wr(8'h03, 8'h01);
		half(8'h10);
		wr(8'h03, 8'hED);
		repeat (40) @(negedge clk_i);
		chk({13'h0, act}, 16'h0001);
		rdchk(8'h03, 8'hED);
		chk({14'h0, cdrv}, 16'h0002);
		chk({14'h0, pdrv}, 16'h0003);
		sleep_i = 1'b1;
		repeat (10) @(negedge clk_i);
		sleep_i = 1'b0;
		// wake takes the synchroniser plus up to one full 1 MHz period to reach the divider
		repeat (40) @(negedge clk_i);
		chk({13'h0, act}, 16'h0005);
		half(8'h01);
	endtask
	task automatic t_freeze();
		@(negedge clk_i);
		ce_i = 1'b0;
		wr(8'h12, 8'h0A);
		wr(8'h03, 8'h02);
		@(negedge clk_i);
		ce_i = 1'b1;
		rdchk(8'h12, 8'hF0);
		rdchk(8'h03, 8'hED);
		chk({13'h0, act}, 16'h0005);
		chk({15'h0, stable}, 16'h0001);
	endtask
	task automatic t_osc();
		wr(8'h03, 8'h00);
		half(8'h00);
		chk({13'h0, act}, 16'h0000);
		wr(8'h12, 8'h4A);
		chk({8'h00, mode, trim}, 16'h004A);
		chk({14'h0, en, ext}, 16'h0003);
		wr(8'h12, 8'h5C);
		chk({8'h00, mode, trim}, 16'h004C);
		wr(8'h12, 8'h00);
		chk({14'h0, en, ext}, 16'h0000);
		wr(8'h03, 8'h08);
		rdchk(8'h03, 8'h08);
	endtask
	initial
	begin
		repeat (20) @(negedge clk_i);
		rst_i = 1'b0;
		t_reset();
		t_settle();
		t_immediate();
		t_shadow();
		t_freeze();
		t_osc();
		complete_run();
	end
	// watchdog sized well beyond the settling wait plus all switch tests
	initial
	begin
		#(40 * 40000);
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
